// ==== include/pfrs_map.vh ====
// Register map, field positions and timing of the flash row sequencer.
`ifndef PFRS_MAP_VH
`define PFRS_MAP_VH
// Register indices; each byte address is four times its index.
`define PFRS_IDX_CTRL    16'h0760
`define PFRS_IDX_ADRL    16'h0762
`define PFRS_IDX_ADRH    16'h0764
`define PFRS_IDX_KEY     16'h0766
`define PFRS_IDX_TPAGE   16'h0770
`define PFRS_IDX_TOFF    16'h0772
`define PFRS_IDX_LATLO   16'h0774
`define PFRS_IDX_LATHI   16'h0776
// Byte addresses on the bus.
`define PFRS_ADDR_CTRL   16'h1d80
`define PFRS_ADDR_ADRL   16'h1d88
`define PFRS_ADDR_ADRH   16'h1d90
`define PFRS_ADDR_KEY    16'h1d98
`define PFRS_ADDR_TPAGE  16'h1dc0
`define PFRS_ADDR_TOFF   16'h1dc8
`define PFRS_ADDR_LATLO  16'h1dd0
`define PFRS_ADDR_LATHI  16'h1dd8
// Control register fields.
`define PFRS_CTRL_GO     15
`define PFRS_CTRL_PERMIT 14
`define PFRS_CTRL_FAULT  13
`define PFRS_CTRL_RSV8   8
`define PFRS_SEL_ERASE   6
`define PFRS_CTRL_RESET  16'h0000
`define PFRS_KEY_RESET   16'h0000
// Unlock key values.
`define PFRS_KEY_FIRST   8'h55
`define PFRS_KEY_SECOND  8'haa
// Row geometry and table pointer step.
`define PFRS_ROW_WORDS   32
`define PFRS_LAST_WORD   5'h1f
`define PFRS_TPTR_STEP   16'h0002
// Operation time and its cycle count.
`define PFRS_CLK_KHZ     200000
`define PFRS_OP_TIME_MS  2
`define PFRS_OP_CYCLES   (`PFRS_OP_TIME_MS * `PFRS_CLK_KHZ)
`endif

// ==== sim/pfrs_chk.sv ====
// Port-level assertions for the flash row sequencer.
`timescale 1ns/1ps
module pfrs_chk #(
    parameter OP_CYCLES = 20
) (
    input wire        pclk,
    input wire        presetn,
    input wire        psel,
    input wire        penable,
    input wire        pwrite,
    input wire [15:0] paddr,
    input wire [31:0] pwdata,
    input wire [31:0] prdata,
    input wire        pready,
    input wire        pslverr,
    input wire        cpu_stall,
    input wire        flash_erase,
    input wire        flash_write,
    input wire [17:0] flash_row,
    input wire [4:0]  flash_word,
    input wire [23:0] flash_data
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    reg [19:0] stall_cnt_r; // Length of the current stall.
    // Count stalled cycles so the length can be judged when it ends.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stall_cnt_r <= 20'h0;
        end else begin
            stall_cnt_r <= cpu_stall ? stall_cnt_r + 20'h1 : 20'h0;
        end
    end
    // One word of a burst that is not yet the last one.
    sequence s_mid;
        flash_write && flash_word != 5'h1f;
    endsequence
    // The final word of a row burst.
    sequence s_last;
        flash_write && flash_word == 5'h1f;
    endsequence
    a_ready_once: assert property (pready |=> !pready)
        else $error("pready held longer than one cycle");
    a_slverr_ready: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    a_erase_stall: assert property (
        flash_erase |-> cpu_stall ##1 (cpu_stall && !flash_erase))
        else $error("erase pulse without stall");
    a_write_stall: assert property (flash_write |-> cpu_stall)
        else $error("flash write outside stall");
    a_stall_hold: assert property (
        $rose(cpu_stall) |-> cpu_stall [*8])
        else $error("stall dropped early");
    a_stall_blocks: assert property (
        $rose(cpu_stall) |-> !pready [*8])
        else $error("bus answered during stall");
    a_stall_length: assert property (
        $fell(cpu_stall) |-> stall_cnt_r >= OP_CYCLES
        && stall_cnt_r <= OP_CYCLES + 48)
        else $error("operation length out of range");
    a_word_first: assert property (
        $rose(flash_write) |-> flash_word == 5'h0)
        else $error("burst not starting at word zero");
    a_word_next: assert property (
        s_mid |=> flash_write && flash_word == $past(flash_word) + 5'h1)
        else $error("burst word out of order");
    a_burst_end: assert property (s_last |=> !flash_write)
        else $error("burst longer than one row");
endmodule
bind pfrs_top pfrs_chk #(.OP_CYCLES(OP_CYCLES)) u_chk (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .cpu_stall(cpu_stall),
    .flash_erase(flash_erase), .flash_write(flash_write),
    .flash_row(flash_row), .flash_word(flash_word),
    .flash_data(flash_data));

// ==== sim/pfrs_flash_model.sv ====
// Behavioural model of the flash row array behind the sequencer.
`timescale 1ns/1ps
module pfrs_flash_model (
    input wire        pclk,
    input wire        flash_erase,
    input wire        flash_write,
    input wire [17:0] flash_row,
    input wire [4:0]  flash_word,
    input wire [23:0] flash_data
);
    reg [23:0] mem [0:31]; // One row image; contents start unknown.
    reg [17:0] row_seen;   // Row of the last erase or write.
    integer    k;
    // Erase sets the whole row to ones; each write stores one word.
    always @(posedge pclk) begin
        if (flash_erase) begin
            row_seen <= flash_row;
            for (k = 0; k < 32; k = k + 1) begin
                mem[k] <= 24'hffffff;
            end
        end
        if (flash_write) begin
            row_seen <= flash_row;
            mem[flash_word] <= flash_data;
        end
    end
endmodule

// ==== sim/program_flash_row_sequencer_test.sv ====
// Self-checking bench for the flash row sequencer.
`timescale 1ns/1ps
`include "pfrs_map.vh"
module program_flash_row_sequencer_test;
    localparam OPC = 20; // Short operation keeps the run brief.
    reg         pclk = 1'b0;
    reg         presetn = 1'b0;
    reg         psel = 1'b0;
    reg         penable = 1'b0;
    reg         pwrite = 1'b0;
    reg  [15:0] paddr = 16'h0;
    reg  [31:0] pwdata = 32'h0;
    wire [31:0] prdata;
    wire        pready, pslverr, cpu_stall, flash_erase, flash_write;
    wire [17:0] flash_row;
    wire [4:0]  flash_word;
    wire [23:0] flash_data;
    integer     fails = 0, comparisons = 0, cyc = 0, i;
    integer     seed = 32'hb916;
    reg  [31:0] rd;
    reg         e;
    reg  [31:0] rnd; // Raw random word, split into fields.
    reg  [15:0] lo [0:31];
    reg  [31:0] hi [0:31];
    reg  [7:0]  page;
    reg  [15:0] toff;
    always #2.5 pclk = ~pclk;
    pfrs_top #(.OP_CYCLES(OPC)) dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .cpu_stall(cpu_stall),
        .flash_erase(flash_erase), .flash_write(flash_write),
        .flash_row(flash_row), .flash_word(flash_word),
        .flash_data(flash_data));
    pfrs_flash_model u_flash (
        .pclk(pclk), .flash_erase(flash_erase), .flash_write(flash_write),
        .flash_row(flash_row), .flash_word(flash_word),
        .flash_data(flash_data));
    // Control read-back: go cleared, a refused start sets the fault,
    // and the unused bits 12:9 and 7 always read as zero.
    function [31:0] ctrl_exp(input [15:0] v, input refused);
        ctrl_exp = {16'h0, 1'b0, v[14], v[13] | refused, 4'h0, v[8],
                    1'b0, v[6:0]};
    endfunction
    task end_sim;
        $display("counts: %0d comparisons, %0d fails", comparisons, fails);
        if (fails == 0 && comparisons > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task chk(input [31:0] got, input [31:0] exp);
        comparisons = comparisons + 1;
        if (got !== exp) begin
            fails = fails + 1;
            $display("mismatch at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    // One APB transfer; waits through a stall until pready comes.
    // Pready is looked at on the rising edge, where the slave samples it.
    task apb(input w, input [15:0] a, input [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task wr(input [15:0] a, input [31:0] d);
        apb(1'b1, a, d);
    endtask
    task rdc(input [15:0] a, input [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask
    task keys;
        wr(`PFRS_ADDR_KEY, 32'h55);
        wr(`PFRS_ADDR_KEY, 32'haa);
    endtask
    // Unlock and start, then leave the bus idle for two cycles.
    task kick(input [31:0] v);
        keys;
        wr(`PFRS_ADDR_CTRL, v);
        repeat (2) @(posedge pclk);
    endtask
    // A hang counts as a failure and ends the run.
    always @(posedge pclk) begin
        cyc = cyc + 1;
        if (cyc == 20000) begin
            fails = fails + 1;
            end_sim;
        end
    end
    initial begin
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        rdc(`PFRS_ADDR_CTRL, 32'h0);
        rdc(`PFRS_ADDR_KEY, 32'h0);
        apb(1'b0, 16'h1d84, 32'h0);
        chk({31'h0, e}, 32'h1);
        chk(rd, 32'h0);
        wr(`PFRS_ADDR_CTRL, 32'hffff3f7f);
        rdc(`PFRS_ADDR_CTRL, ctrl_exp(16'h3f7f, 1'b0));
        $display("test regs done");
        wr(`PFRS_ADDR_CTRL, 32'h4041);
        wr(`PFRS_ADDR_CTRL, 32'hc041);
        rdc(`PFRS_ADDR_CTRL, ctrl_exp(16'hc041, 1'b1));
        wr(`PFRS_ADDR_KEY, 32'h55);
        wr(`PFRS_ADDR_ADRL, 32'h0);
        wr(`PFRS_ADDR_KEY, 32'haa);
        wr(`PFRS_ADDR_CTRL, 32'hc041);
        rdc(`PFRS_ADDR_CTRL, ctrl_exp(16'hc041, 1'b1));
        wr(`PFRS_ADDR_CTRL, 32'h0);
        keys;
        wr(`PFRS_ADDR_CTRL, 32'hc041);
        rdc(`PFRS_ADDR_CTRL, ctrl_exp(16'hc041, 1'b1));
        $display("test refuse done");
        rnd = $random(seed);
        page = rnd[7:0];
        toff = rnd[31:16] & 16'hffc0;
        wr(`PFRS_ADDR_CTRL, 32'h4041);
        wr(`PFRS_ADDR_ADRH, {16'h0, rnd[15:8], page});
        wr(`PFRS_ADDR_ADRL, {16'h0, toff});
        rdc(`PFRS_ADDR_ADRH, {24'h0, page});
        kick(32'hc041);
        rdc(`PFRS_ADDR_CTRL, ctrl_exp(16'h4041, 1'b0));
        chk({14'h0, u_flash.row_seen}, {14'h0, page, toff[15:6]});
        for (i = 0; i < 32; i = i + 1) begin
            chk({8'h0, u_flash.mem[i]}, 32'hffffff);
        end
        wr(`PFRS_ADDR_CTRL, 32'hc041);
        rdc(`PFRS_ADDR_CTRL, ctrl_exp(16'hc041, 1'b1));
        $display("test erase done");
        wr(`PFRS_ADDR_TPAGE, {24'h0, page});
        wr(`PFRS_ADDR_TOFF, {16'h0, toff});
        for (i = 0; i < 32; i = i + 1) begin
            rnd = $random(seed);
            lo[i] = rnd[15:0];
            hi[i] = $random(seed);
            wr(`PFRS_ADDR_LATLO, {hi[i][31:16], lo[i]});
            wr(`PFRS_ADDR_LATHI, hi[i]);
        end
        rdc(`PFRS_ADDR_ADRH, {24'h0, page});
        rdc(`PFRS_ADDR_ADRL, {16'h0, toff + 16'h003e});
        rdc(`PFRS_ADDR_TOFF, {16'h0, toff + 16'h0040});
        rdc(`PFRS_ADDR_TPAGE, {24'h0, page});
        wr(`PFRS_ADDR_CTRL, 32'h4001);
        kick(32'hc001);
        rdc(`PFRS_ADDR_CTRL, ctrl_exp(16'h4001, 1'b0));
        chk({14'h0, u_flash.row_seen}, {14'h0, page, toff[15:6]});
        for (i = 0; i < 32; i = i + 1) begin
            chk({8'h0, u_flash.mem[i]}, {8'h0, hi[i][7:0], lo[i]});
        end
        $display("test program done");
        end_sim;
    end
endmodule

// ==== src/pfrs_latch_mem.v ====
// Row write latches: 32 words of 24 bits with registered read data.
`timescale 1ns/1ps
module pfrs_latch_mem (
    input  wire        clk,
    input  wire        rst_n,
    input  wire        wr_lo,
    input  wire        wr_hi,
    input  wire [4:0]  wr_idx,
    input  wire [15:0] wr_data,
    input  wire [4:0]  rd_idx,
    output reg  [23:0] rd_data
);
    // Latch storage; not reset, software loads it before use.
    reg [23:0] mem [0:31];

    // Low writes fill bits 15:0, high writes keep only the low byte.
    always @(posedge clk) begin
        if (wr_lo) begin
            mem[wr_idx][15:0] <= wr_data;
        end
        if (wr_hi) begin
            mem[wr_idx][23:16] <= wr_data[7:0];
        end
    end

    // Read data come out of a register, one cycle after the index.
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_data <= 24'h000000;
        end else begin
            rd_data <= mem[rd_idx];
        end
    end
endmodule

// ==== src/pfrs_op_timer.v ====
// Cycle timer that measures one erase or program operation.
`timescale 1ns/1ps
module pfrs_op_timer (
    input  wire        clk,
    input  wire        rst_n,
    input  wire        start,
    input  wire [18:0] limit,
    output reg         done
);
    reg [18:0] cnt_r; // Cycles still to run.
    reg        run_r; // High while timing.

    // Done pulses exactly limit cycles after the start edge, for any nonzero limit.
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_r <= 19'h00000;
            run_r <= 1'b0;
            done  <= 1'b0;
        end else begin
            done <= 1'b0;
            if (start) begin
                cnt_r <= limit;
                run_r <= 1'b1;
            end else if (run_r) begin
                // A limit of zero still ends after one cycle.
                if (cnt_r <= 19'h00001) begin
                    run_r <= 1'b0;
                    done  <= 1'b1;
                end else begin
                    cnt_r <= cnt_r - 19'h00001;
                end
            end
        end
    end
endmodule

// ==== src/pfrs_top.v ====
// Program flash row sequencer with its APB register file.
//
// Our own choice: the APB interface to the registers.
`timescale 1ns/1ps
`include "pfrs_map.vh"

module pfrs_top #(
    parameter OP_CYCLES = `PFRS_OP_CYCLES
) (
    input  wire        pclk,
    input  wire        presetn,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [15:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    output reg         cpu_stall,
    output reg         flash_erase,
    output reg         flash_write,
    output reg  [17:0] flash_row,
    output reg  [4:0]  flash_word,
    output reg  [23:0] flash_data
);
    // One-hot sequencer states.
    localparam [3:0] ST_IDLE  = 4'b0001;
    localparam [3:0] ST_ERASE = 4'b0010;
    localparam [3:0] ST_LOAD  = 4'b0100;
    localparam [3:0] ST_PROG  = 4'b1000;

    // Timer limit cut to the counter width.
    localparam [31:0] OP_CYC32 = OP_CYCLES;
    wire [18:0]       op_limit = OP_CYC32[18:0];

    reg  [3:0]  state_r;    // Sequencer state.
    reg  [3:0]  state_nxt;  // Next sequencer state.
    reg         go_r;       // Operation in progress flag.
    reg         permit_r;   // Operations permitted.
    reg         fault_r;    // Refused start seen.
    reg         rsv8_r;     // Spare flag bit, stored only.
    reg  [6:0]  sel_r;      // Operation select field.
    reg  [15:0] adrl_r;     // Address bits 15:0.
    reg  [7:0]  adrh_r;     // Address bits 23:16.
    reg  [7:0]  tpage_r;    // Table page.
    reg  [15:0] toff_r;     // Table offset.
    reg         key1_r;     // First key seen on last write.
    reg         armed_r;    // Full key sequence seen.
    reg  [4:0]  cnt_r;      // Latch read index while loading.
    reg         strm_v_r;   // Latch data valid for output.
    reg  [4:0]  strm_w_r;   // Word index matching latch data.
    reg         tstart_r;   // Timer start pulse.
    reg  [31:0] rd_nxt;     // Read data for the access phase.
    reg         err_nxt;    // Unmapped address flag.

    wire        busy    = ~state_r[0];
    wire        setup   = psel & ~pready;
    wire        wr_fire = psel & penable & pready & pwrite;
    wire        op_done;
    wire [23:0] lat_q;
    wire        wr_ctrl = wr_fire & (paddr == `PFRS_ADDR_CTRL);
    wire        wr_key  = wr_fire & (paddr == `PFRS_ADDR_KEY);
    wire        wr_lo   = wr_fire & (paddr == `PFRS_ADDR_LATLO);
    wire        wr_hi   = wr_fire & (paddr == `PFRS_ADDR_LATHI);
    wire        want_go = pwdata[`PFRS_CTRL_GO];
    // Start only with a fresh unlock and permit set before this write.
    wire        start   = wr_ctrl & want_go & armed_r & permit_r &
                          ~go_r;
    wire        refuse  = wr_ctrl & want_go & ~start & ~go_r;
    wire        erase_s = sel_r[`PFRS_SEL_ERASE];

    // Write latches addressed by the table offset.
    pfrs_latch_mem u_lat (
        .clk     (pclk),
        .rst_n   (presetn),
        .wr_lo   (wr_lo),
        .wr_hi   (wr_hi),
        .wr_idx  (toff_r[5:1]),
        .wr_data (pwdata[15:0]),
        .rd_idx  (cnt_r),
        .rd_data (lat_q)
    );

    // Timer for the nominal operation length.
    pfrs_op_timer u_tmr (
        .clk   (pclk),
        .rst_n (presetn),
        .start (tstart_r),
        .limit (op_limit),
        .done  (op_done)
    );

    // Read mux; write-only and latch ports read as zero.
    always @* begin
        rd_nxt  = 32'h00000000;
        err_nxt = 1'b0;
        case (paddr)
            `PFRS_ADDR_CTRL: begin
                rd_nxt[15:0] = {go_r, permit_r, fault_r, 4'h0,
                                rsv8_r, 1'b0, sel_r};
            end
            `PFRS_ADDR_ADRL: begin
                rd_nxt[15:0] = adrl_r;
            end
            `PFRS_ADDR_ADRH: begin
                rd_nxt[7:0] = adrh_r;
            end
            `PFRS_ADDR_TPAGE: begin
                rd_nxt[7:0] = tpage_r;
            end
            `PFRS_ADDR_TOFF: begin
                rd_nxt[15:0] = toff_r;
            end
            `PFRS_ADDR_KEY, `PFRS_ADDR_LATLO, `PFRS_ADDR_LATHI: begin
                rd_nxt = 32'h00000000;
            end
            default: begin
                err_nxt = 1'b1;
            end
        endcase
    end

    // Bus answer. A setup phase during an operation waits with pready
    // low, which keeps the core stalled on the bus as well.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            prdata  <= 32'h00000000;
            pslverr <= 1'b0;
        end else begin
            pready  <= setup & ~busy;
            pslverr <= setup & ~busy & err_nxt;
            if (setup & ~busy & ~pwrite) begin
                prdata <= rd_nxt;
            end
        end
    end

    // Control register. Software can set go but never clear it.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            go_r     <= 1'b0;
            permit_r <= 1'b0;
            fault_r  <= 1'b0;
            rsv8_r   <= 1'b0;
            sel_r    <= 7'h00;
        end else begin
            if (wr_ctrl) begin
                permit_r <= pwdata[`PFRS_CTRL_PERMIT];
                rsv8_r   <= pwdata[`PFRS_CTRL_RSV8];
                sel_r    <= pwdata[6:0];
                fault_r  <= pwdata[`PFRS_CTRL_FAULT];
            end
            // A refused start sets the fault bit over any clear.
            if (refuse) begin
                fault_r <= 1'b1;
            end
            if (start) begin
                go_r <= 1'b1;
            end else if (op_done) begin
                go_r <= 1'b0;
            end
        end
    end

    // Unlock tracking; any write to another register breaks the key chain.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            key1_r  <= 1'b0;
            armed_r <= 1'b0;
        end else if (wr_key) begin
            key1_r  <= (pwdata[7:0] == `PFRS_KEY_FIRST);
            armed_r <= key1_r &
                       (pwdata[7:0] == `PFRS_KEY_SECOND);
        end else if (wr_fire) begin
            // Control writes use the arm once; others discard it.
            key1_r  <= 1'b0;
            armed_r <= 1'b0;
        end else if (op_done) begin
            armed_r <= 1'b0;
        end
    end

    // Address registers and table pointer.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            adrl_r  <= 16'h0000;
            adrh_r  <= 8'h00;
            tpage_r <= 8'h00;
            toff_r  <= 16'h0000;
        end else begin
            if (wr_fire & (paddr == `PFRS_ADDR_ADRL)) begin
                adrl_r <= pwdata[15:0];
            end
            if (wr_fire & (paddr == `PFRS_ADDR_ADRH)) begin
                adrh_r <= pwdata[7:0];
            end
            if (wr_fire & (paddr == `PFRS_ADDR_TPAGE)) begin
                tpage_r <= pwdata[7:0];
            end
            if (wr_fire & (paddr == `PFRS_ADDR_TOFF)) begin
                toff_r <= pwdata[15:0];
            end
            // A table write records its effective address.
            if (wr_lo | wr_hi) begin
                adrl_r <= toff_r;
                adrh_r <= tpage_r;
            end
            // The high write closes a word and steps the pointer.
            if (wr_hi) begin
                toff_r <= toff_r + `PFRS_TPTR_STEP;
            end
        end
    end

    // Next state of the sequencer.
    always @* begin
        state_nxt = state_r;
        case (state_r)
            ST_IDLE: begin
                if (start & erase_s) begin
                    state_nxt = ST_ERASE;
                end else if (start) begin
                    state_nxt = ST_LOAD;
                end
            end
            ST_ERASE: begin
                if (op_done) begin
                    state_nxt = ST_IDLE;
                end
            end
            ST_LOAD: begin
                if (cnt_r == `PFRS_LAST_WORD) begin
                    state_nxt = ST_PROG;
                end
            end
            ST_PROG: begin
                if (op_done) begin
                    state_nxt = ST_IDLE;
                end
            end
            default: begin
                state_nxt = ST_IDLE;
            end
        endcase
    end

    // Sequencer registers, timer start and stall output.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r   <= ST_IDLE;
            cnt_r     <= 5'h00;
            tstart_r  <= 1'b0;
            cpu_stall <= 1'b0;
        end else begin
            state_r   <= state_nxt;
            cpu_stall <= ~state_nxt[0];
            // Erase times from its start; program after the stream.
            tstart_r  <= (start & erase_s) |
                         (state_r[2] & state_nxt[3]);
            if (state_r[2]) begin
                cnt_r <= cnt_r + 5'h01;
            end else begin
                cnt_r <= 5'h00;
            end
        end
    end

    // Flash array strobes. The row is fixed at the start.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            strm_v_r    <= 1'b0;
            strm_w_r    <= 5'h00;
            flash_erase <= 1'b0;
            flash_write <= 1'b0;
            flash_row   <= 18'h00000;
            flash_word  <= 5'h00;
            flash_data  <= 24'h000000;
        end else begin
            strm_v_r    <= state_r[2];
            strm_w_r    <= cnt_r;
            flash_erase <= start & erase_s;
            flash_write <= strm_v_r;
            if (start) begin
                flash_row <= {adrh_r, adrl_r[15:6]};
            end
            if (strm_v_r) begin
                flash_word <= strm_w_r;
                flash_data <= lat_q;
            end
        end
    end
endmodule
